// *** info_area_defines.svh ***
// Constants for the information-area overlay: address map, fields, resets.
`ifndef INFO_AREA_DEFINES_SVH
`define INFO_AREA_DEFINES_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define ADDR_W          16
`define DATA_W          8
`define INFO_AW         9

// ----------------------------------------------------------------------
// Address map and control fields
// ----------------------------------------------------------------------
`define INFO_BYTES      512
`define INFO_BASE       16'hFE00
`define INFO_LAST       16'hFFFF
`define PAGE_SEL_EN_BIT 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ADDR_RST        16'h0000
`define DATA_RST        8'h00
`define INFO_ADDR_RST   9'h000

`endif

// *** info_area_pkg.sv ***
// Types shared by the information-area overlay and its store.
package info_area_pkg;

	// ------------------------------------------------------------------
	// Kinds of memory access presented by the core and the debugger
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ACC_FETCH,
		ACC_CONST_LOAD,
		ACC_CONST_LOAD_INCR,
		ACC_DEBUG
	} access_t;

endpackage : info_area_pkg

// *** info_area_store.sv ***
// Factory-loaded information-area store with a registered read port.
`timescale 1ns/1ns
`include "info_area_defines.svh"

module info_area_store
	import info_area_pkg::*;
(
	// Clock
	input  wire logic                   clk,
	// Read port
	input  wire logic                   rd_en,
	input  wire logic [`INFO_AW-1:0]    rd_addr,
	output logic      [`DATA_W-1:0]     rd_data,
	// Factory load port, the only way the contents change
	input  wire logic                   ld_we,
	input  wire logic [`INFO_AW-1:0]    ld_addr,
	input  wire logic [`DATA_W-1:0]     ld_data
);

	typedef struct packed {
		logic [`DATA_W-1:0] rd_data;
	} store_st_t;

	logic [`DATA_W-1:0] mem [`INFO_BYTES];
	store_st_t          st_q;
	store_st_t          st_d;

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (ld_we) begin
			mem[ld_addr] <= ld_data;
		end
	end

	always_comb begin
		st_d = st_q;
		if (rd_en) begin
			st_d.rd_data = mem[rd_addr];
		end
	end

	always_ff @(posedge clk) begin
		st_q <= st_d;
	end

	assign rd_data = st_q.rd_data;

endmodule : info_area_store

// *** info_area_overlay.sv ***
// Read-path overlay of the information area onto the top of program memory.
`timescale 1ns/1ns
`include "info_area_defines.svh"

// Contract
// - Page-select bit 7 set enables the overlay
// - Overlay covers FE00H to FFFFH, 512 bytes
// - Constant loads in range read information area
// - Debugger reads in range read information area
// - Instruction fetches always come from program memory
// - Information area is never written through overlay
module info_area_overlay
	import info_area_pkg::*;
(
	// Clock and reset
	input  wire logic                   CLK,
	input  wire logic                   SRST,
	// Page-select control byte from the core
	input  wire logic [7:0]             PAGE_SEL,
	// Access request from the core or debugger
	input  wire logic                   REQ_VALID,
	input  wire logic [1:0]             REQ_TYPE,
	input  wire logic                   REQ_WRITE,
	input  wire logic [`ADDR_W-1:0]     REQ_ADDR,
	input  wire logic [`DATA_W-1:0]     REQ_WDATA,
	// Read answer to the requester
	output logic                        RSP_VALID,
	output logic [`DATA_W-1:0]          RSP_DATA,
	output logic                        RSP_FROM_INFO,
	// Program memory array
	output logic                        PM_RD,
	output logic                        PM_WR,
	output logic [`ADDR_W-1:0]          PM_ADDR,
	output logic [`DATA_W-1:0]          PM_WDATA,
	input  wire logic [`DATA_W-1:0]     PM_RDATA,
	// Status
	output logic                        OVERLAY_ON,
	output logic                        WR_BLOCKED,
	// Factory load of the information area
	input  wire logic                   INFO_LOAD_WE,
	input  wire logic [`INFO_AW-1:0]    INFO_LOAD_ADDR,
	input  wire logic [`DATA_W-1:0]     INFO_LOAD_DATA
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic                   s1_vld;
		logic                   s1_info;
		logic [`INFO_AW-1:0]    s1_iaddr;
		logic                   s2_vld;
		logic                   s2_info;
		logic                   pm_rd;
		logic                   pm_wr;
		logic [`ADDR_W-1:0]     pm_addr;
		logic [`DATA_W-1:0]     pm_wdata;
		logic                   rsp_vld;
		logic [`DATA_W-1:0]     rsp_data;
		logic                   rsp_info;
		logic                   ovl_on;
		logic                   wr_blk;
	} ovl_st_t;

	ovl_st_t                st_q;
	ovl_st_t                st_d;
	access_t                acc;
	logic                   ovl_en;
	logic                   in_range;
	logic                   info_hit;
	logic                   rd_req;
	logic                   wr_req;
	logic [`DATA_W-1:0]     info_rdata;

	// ------------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------------
	always_comb begin
		acc    = access_t'(REQ_TYPE);
		ovl_en = PAGE_SEL[`PAGE_SEL_EN_BIT];
		// The top of the window is the top of the address space.
		in_range = (REQ_ADDR >= `INFO_BASE) &&
			(REQ_ADDR <= `INFO_LAST);
		rd_req = REQ_VALID && !REQ_WRITE;
		wr_req = REQ_VALID && REQ_WRITE;
		info_hit = 1'b0;
		if (ovl_en && in_range) begin
			case (acc)
				ACC_CONST_LOAD: begin
					info_hit = 1'b1;
				end
				ACC_CONST_LOAD_INCR: begin
					info_hit = 1'b1;
				end
				ACC_DEBUG: begin
					info_hit = 1'b1;
				end
				ACC_FETCH: begin
					info_hit = 1'b0;
				end
				default: begin
					info_hit = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Information-area store
	// ------------------------------------------------------------------
	// Read one cycle after acceptance so its data line up with the
	// program memory answer and back-to-back reads pipeline cleanly.
	info_area_store u_store (
		.clk     (CLK),
		.rd_en   (st_q.s1_vld && st_q.s1_info),
		.rd_addr (st_q.s1_iaddr),
		.rd_data (info_rdata),
		.ld_we   (INFO_LOAD_WE),
		.ld_addr (INFO_LOAD_ADDR),
		.ld_data (INFO_LOAD_DATA)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		st_d = st_q;

		// Stage 1: accept a read and route it.
		st_d.s1_vld   = rd_req;
		st_d.s1_info  = rd_req && info_hit;
		st_d.s1_iaddr = REQ_ADDR[`INFO_AW-1:0];

		// Program memory sees every read that the overlay does not take.
		st_d.pm_rd = rd_req && !info_hit;
		st_d.pm_wr = 1'b0;
		if (rd_req) begin
			st_d.pm_addr = REQ_ADDR;
		end

		// Non-fetch writes into the overlaid window are dropped; the store has no
		// write path from the requester at all.
		st_d.wr_blk = wr_req && info_hit;
		if (wr_req && !info_hit) begin
			st_d.pm_wr    = 1'b1;
			st_d.pm_addr  = REQ_ADDR;
			st_d.pm_wdata = REQ_WDATA;
		end

		// Stage 2: both sources hold their data during this cycle.
		st_d.s2_vld  = st_q.s1_vld;
		st_d.s2_info = st_q.s1_info;

		// Answer, registered for the requester.
		st_d.rsp_vld  = st_q.s2_vld;
		st_d.rsp_info = st_q.s2_vld && st_q.s2_info;
		if (st_q.s2_vld) begin
			st_d.rsp_data = st_q.s2_info ? info_rdata
				: PM_RDATA;
		end

		st_d.ovl_on = ovl_en;

		if (SRST) begin
			st_d.s1_vld   = 1'b0;
			st_d.s1_info  = 1'b0;
			st_d.s1_iaddr = `INFO_ADDR_RST;
			st_d.s2_vld   = 1'b0;
			st_d.s2_info  = 1'b0;
			st_d.pm_rd    = 1'b0;
			st_d.pm_wr    = 1'b0;
			st_d.pm_addr  = `ADDR_RST;
			st_d.pm_wdata = `DATA_RST;
			st_d.rsp_vld  = 1'b0;
			st_d.rsp_data = `DATA_RST;
			st_d.rsp_info = 1'b0;
			st_d.ovl_on   = 1'b0;
			st_d.wr_blk   = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge CLK) begin
		st_q <= st_d;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign RSP_VALID     = st_q.rsp_vld;
	assign RSP_DATA      = st_q.rsp_data;
	assign RSP_FROM_INFO = st_q.rsp_info;
	assign PM_RD         = st_q.pm_rd;
	assign PM_WR         = st_q.pm_wr;
	assign PM_ADDR       = st_q.pm_addr;
	assign PM_WDATA      = st_q.pm_wdata;
	assign OVERLAY_ON    = st_q.ovl_on;
	assign WR_BLOCKED    = st_q.wr_blk;

endmodule : info_area_overlay

// *** info_area_overlay_assertions.sv ***
// Concurrent checks on the overlay ports.
`timescale 1ns/1ns
`include "info_area_defines.svh"
module info_area_overlay_assertions
	import info_area_pkg::*;
(
	// Clock and reset
	input wire logic        CLK,
	input wire logic        SRST,
	// Request side
	input wire logic [7:0]  PAGE_SEL,
	input wire logic        REQ_VALID,
	input wire logic [1:0]  REQ_TYPE,
	input wire logic        REQ_WRITE,
	input wire logic [15:0] REQ_ADDR,
	// Answers and memory side
	input wire logic        RSP_VALID,
	input wire logic        RSP_FROM_INFO,
	input wire logic        PM_RD,
	input wire logic        PM_WR,
	input wire logic [15:0] PM_ADDR,
	input wire logic        OVERLAY_ON,
	input wire logic        WR_BLOCKED
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	logic hit;
	assign hit = PAGE_SEL[7] && REQ_TYPE != 2'h0 && REQ_ADDR >= `INFO_BASE;
	sequence rd_req;
		REQ_VALID && !REQ_WRITE;
	endsequence
	sequence info_rd;
		rd_req ##0 hit;
	endsequence
	a_enable_copy: assert property (
		!$past(SRST) |-> OVERLAY_ON == $past(PAGE_SEL[7]))
		else $error("overlay status does not follow enable bit");
	a_info_no_pm: assert property (info_rd |-> ##1 !PM_RD)
		else $error("program memory read for overlaid address");
	a_info_answer: assert property (
		info_rd |-> ##3 RSP_VALID && RSP_FROM_INFO)
		else $error("overlaid read not answered from info area");
	a_fetch_pm: assert property (rd_req ##0 REQ_TYPE == 2'h0 |->
		##1 PM_RD && PM_ADDR == $past(REQ_ADDR) ##2 RSP_VALID && !RSP_FROM_INFO)
		else $error("fetch not served by program memory");
	a_below_pm: assert property (
		rd_req ##0 REQ_ADDR < `INFO_BASE |-> ##1 PM_RD)
		else $error("read below window missed program memory");
	a_off_pm: assert property (
		rd_req ##0 !PAGE_SEL[7] |-> ##3 RSP_VALID && !RSP_FROM_INFO)
		else $error("read with overlay off not from program memory");
	a_write_blocked: assert property (
		REQ_VALID && REQ_WRITE && hit |-> ##1 WR_BLOCKED && !PM_WR)
		else $error("write through overlay not dropped");
	a_write_forward: assert property (REQ_VALID && REQ_WRITE && !hit |->
		##1 PM_WR && !WR_BLOCKED && PM_ADDR == $past(REQ_ADDR))
		else $error("write outside overlay not forwarded");
endmodule : info_area_overlay_assertions
bind info_area_overlay info_area_overlay_assertions u_chk (.CLK, .SRST,
	.PAGE_SEL, .REQ_VALID, .REQ_TYPE, .REQ_WRITE, .REQ_ADDR, .RSP_VALID,
	.RSP_FROM_INFO, .PM_RD, .PM_WR, .PM_ADDR, .OVERLAY_ON, .WR_BLOCKED);

// *** pm_model.sv ***
// Program memory model answering in the cycle after each read strobe.
`timescale 1ns/1ns
module pm_model (
	// Program memory port
	input  wire logic        clk,
	input  wire logic        pm_rd,
	input  wire logic        pm_wr,
	input  wire logic [15:0] pm_addr,
	input  wire logic [7:0]  pm_wdata,
	output logic      [7:0]  pm_rdata
);
	logic [7:0] mem [logic [15:0]];
	initial pm_rdata = 8'h00;
	// Outside a read answer the data toggles so stale values never match.
	always @(posedge clk) begin
		if (pm_wr)
			mem[pm_addr] = pm_wdata;
		if (pm_rd)
			pm_rdata <= mem.exists(pm_addr) ? mem[pm_addr]
				: pm_addr[7:0] ^ pm_addr[15:8] ^ 8'h5A;
		else
			pm_rdata <= ~pm_rdata;
	end
endmodule : pm_model

// *** test_info_area_overlay.sv ***
// Self-checking bench for the information-area overlay.
`timescale 1ns/1ns
`include "info_area_defines.svh"
module test_info_area_overlay
	import info_area_pkg::*;
;
	logic        CLK = 0, SRST = 1, REQ_VALID = 0, REQ_WRITE = 0;
	logic [1:0]  REQ_TYPE = 0;
	logic [7:0]  PAGE_SEL = 0, REQ_WDATA = 0, INFO_LOAD_DATA = 0;
	logic [15:0] REQ_ADDR = 0, PM_ADDR;
	logic        INFO_LOAD_WE = 0, RSP_VALID, RSP_FROM_INFO, PM_RD, PM_WR;
	logic        OVERLAY_ON, WR_BLOCKED, exp_ovl = 0, exp_blk = 0;
	logic [8:0]  INFO_LOAD_ADDR = 0;
	logic [7:0]  RSP_DATA, PM_WDATA, PM_RDATA;
	int          fails = 0, n_tests = 0;
	logic [7:0]  info [512];
	logic [7:0]  pm [logic [15:0]];
	logic [8:0]  exp_q [$];
	logic [15:0] edge_a [3] = '{16'hFDFF, 16'hFE00, 16'hFFFF};
	info_area_overlay DUT (.CLK, .SRST, .PAGE_SEL, .REQ_VALID, .REQ_TYPE,
		.REQ_WRITE, .REQ_ADDR, .REQ_WDATA, .RSP_VALID, .RSP_DATA,
		.RSP_FROM_INFO, .PM_RD, .PM_WR, .PM_ADDR, .PM_WDATA, .PM_RDATA,
		.OVERLAY_ON, .WR_BLOCKED, .INFO_LOAD_WE, .INFO_LOAD_ADDR,
		.INFO_LOAD_DATA);
	pm_model u_pm (.clk(CLK), .pm_rd(PM_RD), .pm_wr(PM_WR), .pm_addr(PM_ADDR),
		.pm_wdata(PM_WDATA), .pm_rdata(PM_RDATA));
	initial begin
		forever #25 CLK = ~CLK;
	end
	task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	// Issues one request per cycle and records the answer it must get.
	task automatic req(logic [1:0] t, logic w, logic [15:0] a, logic en);
		logic hit;
		hit = en && t != 2'h0 && a >= `INFO_BASE;
		@(posedge CLK);
		#2;
		{REQ_VALID, REQ_TYPE, REQ_WRITE, REQ_ADDR} = {1'b1, t, w, a};
		PAGE_SEL = {en, 7'($urandom)};
		REQ_WDATA = 8'($urandom);
		if (w && !hit)
			pm[a] = REQ_WDATA;
		if (!w)
			exp_q.push_back({hit, hit ? info[a[8:0]] : pm.exists(a) ? pm[a]
				: a[7:0] ^ a[15:8] ^ 8'h5A});
	endtask : req
	always @(posedge CLK) begin
		if (RSP_VALID === 1'b1) begin
			if (exp_q.size() == 0)
				check("stray answer", 9'h1, 9'h0);
			else
				check("answer", {RSP_FROM_INFO, RSP_DATA}, exp_q.pop_front());
		end
	end
	// Status outputs answer the request and enable of the edge before.
	always @(posedge CLK) begin
		if (SRST === 1'b0) begin
			check("overlay on", 9'(OVERLAY_ON), 9'(exp_ovl));
			check("write blocked", 9'(WR_BLOCKED), 9'(exp_blk));
		end
		exp_ovl <= !SRST && PAGE_SEL[7];
		exp_blk <= !SRST && REQ_VALID && REQ_WRITE && PAGE_SEL[7] &&
			REQ_TYPE != 2'h0 && REQ_ADDR >= `INFO_BASE;
	end
	initial begin
		void'($urandom(32'h3AE4));
		repeat (8) @(posedge CLK);
		#2 SRST = 0;
		for (int i = 0; i < 512; i++) begin
			@(posedge CLK);
			#2;
			info[i] = 8'($urandom);
			{INFO_LOAD_WE, INFO_LOAD_ADDR, INFO_LOAD_DATA} = {1'b1, 9'(i), info[i]};
		end
		@(posedge CLK);
		#2 INFO_LOAD_WE = 0;
		$display("test load done");
		for (int k = 0; k < 24; k++)
			req(k[1:0], 1'b0, edge_a[k / 8], k[2]);
		req(2'h1, 1'b1, 16'hFE00, 1'b1);
		req(2'h1, 1'b0, 16'hFE00, 1'b1);
		req(2'h3, 1'b1, 16'hFE01, 1'b0);
		req(2'h3, 1'b0, 16'hFE01, 1'b0);
		req(2'h0, 1'b1, 16'hFFFF, 1'b1);
		req(2'h0, 1'b0, 16'hFFFF, 1'b1);
		$display("test boundaries done");
		for (int k = 0; k < 400; k++)
			req(2'($urandom), $urandom_range(3) == 0, ($urandom & 1) ?
				{7'h7F, 9'($urandom)} : 16'($urandom), 1'($urandom));
		@(posedge CLK);
		#2 REQ_VALID = 0;
		for (int i = 0; i < 10 && exp_q.size() > 0; i++)
			@(posedge CLK);
		check("answers missing", 9'(exp_q.size()), 9'h000);
		$display("test random traffic done");
		summarize();
	end
endmodule : test_info_area_overlay
